//--- shared/asrp_regs.vh
`ifndef ASRP_REGS_VH
`define ASRP_REGS_VH

// ************************************************************
// frame layout
// ************************************************************
`define ASRP_FRAME_BITS   30
`define ASRP_ADDR_BITS    10
`define ASRP_DATA_BITS    20
`define ASRP_CNT_W        5
`define ASRP_CNT_MAX      5'h1F

// ************************************************************
// control register at address 0
// ************************************************************
`define ASRP_ADDR_CTRL    10'h000
`define ASRP_CTRL_RW_BIT  0
`define ASRP_CTRL_DIR_BIT 1
`define ASRP_CTRL_SDO_BIT 2
`define ASRP_CTRL_RESET   20'h00000
`define ASRP_REG_RESET    20'h00000

`endif

//--- hw/asrp_sync.v
`default_nettype none

// ************************************************************
// two-stage synchroniser for pin inputs
// ************************************************************
module asrp_sync #(
    parameter             WIDTH   = 3,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input  wire             i_clk_sys,
    input  wire             i_rst,
    input  wire [WIDTH-1:0] i_d,
    output wire [WIDTH-1:0] o_q
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage; reset holds the idle
    // level of each pin so that release shows no edge
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;

endmodule

`default_nettype wire

//--- hw/asrp_port.v
`include "asrp_regs.vh"
`default_nettype none

// ************************************************************
// serial register port of the front-end
// ************************************************************
module asrp_port #(
    parameter REG_COUNT = 16,
    parameter IDX_W     = 4
) (
    input  wire        i_clk_sys,
    input  wire        i_rst,
    input  wire        i_sclk,
    input  wire        i_frame_latch_enable,
    input  wire        i_sdi,
    output wire        o_sdi_out,
    output wire        o_sdi_oe,
    output wire        o_sdi_pull_down,
    output wire        o_sdo,
    output wire        o_sdo_oe,
    output wire        o_read_mode,
    output wire        o_wr_stb,
    output wire [9:0]  o_wr_addr,
    output wire [19:0] o_wr_data,
    output wire        o_frame_drop
);

    // ********************************************************
    // pin synchronisers and edge detection
    // ********************************************************
    wire [2:0] pins_s;
    wire       sclk_s;
    wire       sen_s;
    wire       sdi_s;

    // frame enable idles high, so its synchroniser resets high too
    asrp_sync #(
        .WIDTH   (3),
        .RST_VAL (3'h2)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_d       ({i_sclk, i_frame_latch_enable, i_sdi}),
        .o_q       (pins_s)
    );

    assign sclk_s = pins_s[2];
    assign sen_s  = pins_s[1];
    assign sdi_s  = pins_s[0];

    reg sclk_p_q;
    reg sen_p_q;

    wire sclk_rise = sclk_s & ~sclk_p_q;
    wire sclk_fall = ~sclk_s & sclk_p_q;
    wire sen_rise  = sen_s & ~sen_p_q;

    // ********************************************************
    // state
    // ********************************************************
    reg [`ASRP_FRAME_BITS-1:0] shift_q;
    reg [`ASRP_CNT_W-1:0]      cnt_q;
    reg [`ASRP_DATA_BITS-1:0]  ctrl_q;
    reg [`ASRP_DATA_BITS-1:0]  regs_q [0:REG_COUNT-1];
    reg [`ASRP_DATA_BITS-1:0]  rd_q;
    reg                        rd_act_q;
    reg                        sdi_oe_q;
    reg                        pull_q;
    reg                        wr_stb_q;
    reg [`ASRP_ADDR_BITS-1:0]  wr_addr_q;
    reg [`ASRP_DATA_BITS-1:0]  wr_data_q;
    reg                        drop_q;

    wire read_mode = ctrl_q[`ASRP_CTRL_RW_BIT];
    wire dir_ctrl  = ctrl_q[`ASRP_CTRL_DIR_BIT];

    // address and data fields of the collected frame
    wire [`ASRP_ADDR_BITS-1:0] fr_addr =
        shift_q[`ASRP_FRAME_BITS-1:`ASRP_DATA_BITS];
    wire [`ASRP_DATA_BITS-1:0] fr_data =
        shift_q[`ASRP_DATA_BITS-1:0];
    // during a read only the address has arrived so far
    wire [`ASRP_ADDR_BITS-1:0] rd_addr =
        shift_q[`ASRP_ADDR_BITS-1:0];

    // ********************************************************
    // register decode
    // ********************************************************
    // addresses beyond the stored set read zero and ignore writes
    function in_store;
        input [`ASRP_ADDR_BITS-1:0] a;
        begin
            in_store = (a != `ASRP_ADDR_CTRL) && (a < REG_COUNT);
        end
    endfunction

    function [`ASRP_DATA_BITS-1:0] rd_word;
        input [`ASRP_ADDR_BITS-1:0] a;
        begin
            if (a == `ASRP_ADDR_CTRL) begin
                rd_word = ctrl_q;
            end else if (in_store(a)) begin
                rd_word = regs_q[a[IDX_W-1:0]];
            end else begin
                rd_word = {`ASRP_DATA_BITS{1'b0}};
            end
        end
    endfunction

    // in read mode only the control word may be written, so that
    // software can always leave read mode again
    wire commit_ok = (cnt_q == `ASRP_FRAME_BITS) &&
                     (!read_mode || fr_addr == `ASRP_ADDR_CTRL);
    wire addr_done = (cnt_q == `ASRP_ADDR_BITS);

    // ********************************************************
    // pin history for edge detection
    // ********************************************************
    // history resets to the idle pin levels, so the release of
    // reset is never taken for an edge
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sclk_p_q <= 1'b0;
            sen_p_q  <= 1'b1;
        end else begin
            sclk_p_q <= sclk_s;
            sen_p_q  <= sen_s;
        end
    end

    // ********************************************************
    // shift and latch
    // ********************************************************
    integer i;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            shift_q   <= {`ASRP_FRAME_BITS{1'b0}};
            cnt_q     <= {`ASRP_CNT_W{1'b0}};
            ctrl_q    <= `ASRP_CTRL_RESET;
            pull_q    <= 1'b1;
            wr_stb_q  <= 1'b0;
            wr_addr_q <= {`ASRP_ADDR_BITS{1'b0}};
            wr_data_q <= {`ASRP_DATA_BITS{1'b0}};
            drop_q    <= 1'b0;
            for (i = 0; i < REG_COUNT; i = i + 1) begin
                regs_q[i] <= `ASRP_REG_RESET;
            end
        end else begin
            wr_stb_q <= 1'b0;
            drop_q   <= 1'b0;
            pull_q   <= 1'b1;
            if (sen_rise) begin
                // end of frame: restart the count
                cnt_q    <= {`ASRP_CNT_W{1'b0}};
                if (commit_ok) begin
                    wr_stb_q  <= 1'b1;
                    wr_addr_q <= fr_addr;
                    wr_data_q <= fr_data;
                    if (fr_addr == `ASRP_ADDR_CTRL) begin
                        ctrl_q <= fr_data;
                    end else if (in_store(fr_addr)) begin
                        regs_q[fr_addr[IDX_W-1:0]] <= fr_data;
                    end
                end else if (cnt_q != `ASRP_FRAME_BITS) begin
                    // short or over-long frames change nothing
                    drop_q <= (cnt_q != {`ASRP_CNT_W{1'b0}});
                end
            end else if (!sen_s && sclk_rise) begin
                shift_q <= {shift_q[`ASRP_FRAME_BITS-2:0], sdi_s};
                if (cnt_q != `ASRP_CNT_MAX) begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end

    // ********************************************************
    // readback
    // ********************************************************
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rd_q     <= {`ASRP_DATA_BITS{1'b0}};
            rd_act_q <= 1'b0;
            sdi_oe_q <= 1'b0;
        end else if (sen_rise) begin
            // end of frame: release the pin
            sdi_oe_q <= 1'b0;
            rd_act_q <= 1'b0;
            rd_q     <= {`ASRP_DATA_BITS{1'b0}};
        end else if (!sen_s && sclk_fall) begin
            // the control word is never read back, so a frame
            // to address 0 in read mode stays a plain write
            if (read_mode && addr_done && !rd_act_q &&
                rd_addr != `ASRP_ADDR_CTRL) begin
                rd_q     <= rd_word(rd_addr);
                rd_act_q <= 1'b1;
                sdi_oe_q <= dir_ctrl;
            end else if (rd_act_q) begin
                rd_q <= {rd_q[`ASRP_DATA_BITS-2:0], 1'b0};
            end
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    // the readback pin only leaves gpio use when its enable bit is set
    assign o_sdi_out       = rd_q[`ASRP_DATA_BITS-1];
    assign o_sdi_oe        = sdi_oe_q;
    assign o_sdi_pull_down = pull_q;
    assign o_sdo           = rd_q[`ASRP_DATA_BITS-1];
    assign o_sdo_oe        = ctrl_q[`ASRP_CTRL_SDO_BIT];
    assign o_read_mode     = ctrl_q[`ASRP_CTRL_RW_BIT];
    assign o_wr_stb        = wr_stb_q;
    assign o_wr_addr       = wr_addr_q;
    assign o_wr_data       = wr_data_q;
    assign o_frame_drop    = drop_q;

endmodule

`default_nettype wire

//--- verif/asrp_host.sv
`default_nettype none

// ************************************************************
// serial master on the far side of the port
// ************************************************************
module asrp_host (
    input  wire logic i_clk,
    input  wire logic i_rx,
    output var  logic o_sclk,
    output var  logic o_sen,
    output var  logic o_d,
    output var  logic o_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sclk = 1'b0;
        o_sen  = 1'b1;
        o_d    = 1'b0;
        o_oe   = 1'b0;
    end
    task automatic half();
        repeat (10) @(negedge i_clk);
    endtask
    // sclk stands low outside frames; rd releases the pin after the address
    task automatic xfer(input int n, input logic [29:0] f, input bit rd,
                        output logic [19:0] q);
        q = 20'h00000;
        o_sen = 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            o_oe = !(rd && i < 20);
            o_d = f[i];
            half();
            o_sclk = 1'b1;
            if (i < 20) q = {q[18:0], i_rx};
            half();
            o_sclk = 1'b0;
        end
        half();
        o_sen = 1'b1;
        o_oe = 1'b0;
        repeat (8) @(negedge i_clk);
    endtask
endmodule

`default_nettype wire

//--- verif/asrp_port_monitor.sv
`default_nettype none

// ************************************************************
// port checker
// ************************************************************
module asrp_port_monitor (
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_sclk,
    input wire logic        i_frame_latch_enable,
    input wire logic        i_sdi,
    input wire logic        o_sdi_out,
    input wire logic        o_sdi_oe,
    input wire logic        o_sdi_pull_down,
    input wire logic        o_sdo,
    input wire logic        o_sdo_oe,
    input wire logic        o_read_mode,
    input wire logic        o_wr_stb,
    input wire logic [9:0]  o_wr_addr,
    input wire logic [19:0] o_wr_data,
    input wire logic        o_frame_drop
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_pull_down_on: assert property (o_sdi_pull_down)
        else $error("pull-down off");
    a_stb_one_cycle: assert property (o_wr_stb |=> !o_wr_stb)
        else $error("commit strobe too long");
    a_commit_after_enable: assert property (o_wr_stb |->
        i_frame_latch_enable && !$past(i_frame_latch_enable, 6))
        else $error("commit without enable rise");
    a_wr_hold: assert property ($changed(o_wr_data) || $changed(o_wr_addr)
        |-> o_wr_stb)
        else $error("write fields moved without commit");
    a_mode_from_ctrl: assert property ($changed(o_read_mode) ||
        $changed(o_sdo_oe) |-> o_wr_stb && o_wr_addr == 10'h000)
        else $error("mode moved without control write");
    a_oe_in_frame: assert property (o_sdi_oe |->
        o_read_mode && !$past(i_frame_latch_enable, 5))
        else $error("pin driven outside read frame");
    a_oe_on_fall: assert property ($rose(o_sdi_oe) |->
        !i_sclk && $past(i_sclk, 6))
        else $error("pin turned not on a fall");
    a_sdo_on_fall: assert property ($changed(o_sdo) |-> !i_sclk)
        else $error("read bit moved while clock high");
    a_sdo_same_bit: assert property ((o_sdo == o_sdi_out) &&
        (!o_sdo || o_read_mode))
        else $error("readback pins disagree");
    c_commit: cover property (o_wr_stb);
    c_drop: cover property (o_frame_drop);
    c_turn: cover property ($rose(o_sdi_oe));
endmodule

bind asrp_port asrp_port_monitor u_mon (.*);

`default_nettype wire

//--- verif/asrp_port_tb.sv
`default_nettype none

// ************************************************************
// bench
// ************************************************************
module asrp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0, i_rst = 1'b1, four = 1'b0, oe_seen = 1'b0;
    wire logic sclk, frame_latch_enable, h_d, h_oe, rx, pin, s_out, s_oe, pd, sdo, sdo_oe;
    wire logic rmode, stb, drop;
    wire logic [9:0] addr;
    wire logic [19:0] data;
    int fail_count = 0, checked = 0, stbs = 0, drops = 0;
    // pull-down wins when nobody drives the pin
    assign pin = s_oe ? s_out : (h_oe ? h_d : 1'b0);
    // a readback pin left to gpio shows the wrong level
    assign rx = four ? (sdo_oe ? sdo : ~sdo) : pin;
    always #4 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        if (stb === 1'b1) stbs++;
        if (drop === 1'b1) drops++;
        if (s_oe === 1'b1) oe_seen = 1'b1;
    end
    asrp_host h (.i_clk(i_clk_sys), .i_rx(rx), .o_sclk(sclk), .o_sen(frame_latch_enable),
        .o_d(h_d), .o_oe(h_oe));
    asrp_port uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sclk(sclk),
        .i_frame_latch_enable(frame_latch_enable), .i_sdi(pin), .o_sdi_out(s_out),
        .o_sdi_oe(s_oe), .o_sdi_pull_down(pd), .o_sdo(sdo),
        .o_sdo_oe(sdo_oe), .o_read_mode(rmode), .o_wr_stb(stb),
        .o_wr_addr(addr), .o_wr_data(data), .o_frame_drop(drop));
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_write_short();
        logic [19:0] q;
        int s, d;
        chk(20'(rmode), 20'h0);
        chk(20'(pd), 20'h1);
        s = stbs;
        h.xfer(30, {10'h005, 20'hABCDE}, 0, q);
        chk(20'(stbs - s), 20'h1);
        chk(20'(addr), 20'h005);
        chk(data, 20'hABCDE);
        d = drops;
        h.xfer(29, {11'h00C, 19'h7FFFF}, 0, q);
        chk(20'(stbs - s), 20'h1);
        chk(20'(drops - d), 20'h1);
        chk(20'(addr), 20'h005);
        $display("test write and short frame done");
    endtask
    task automatic t_reads();
        logic [19:0] q;
        h.xfer(30, {10'h000, 20'h00005}, 0, q);
        chk(20'(rmode), 20'h1);
        chk(20'(sdo_oe), 20'h1);
        four = 1'b1;
        h.xfer(30, {10'h005, 20'h00000}, 0, q);
        chk(q, 20'hABCDE);
        chk(20'(oe_seen), 20'h0);
        h.xfer(30, {10'h000, 20'h00003}, 0, q);
        four = 1'b0;
        h.xfer(30, {10'h005, 20'h00000}, 1, q);
        chk(q, 20'hABCDE);
        chk(20'(oe_seen), 20'h1);
        chk(20'(s_oe), 20'h0);
        h.xfer(30, {10'h000, 20'h00000}, 0, q);
        chk(20'(rmode), 20'h0);
        $display("test four and three wire reads done");
    endtask
    initial begin
        repeat (6) @(posedge i_clk_sys);
        @(negedge i_clk_sys) i_rst = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        t_write_short();
        t_reads();
        give_verdict();
    end
    initial begin
        #200us;
        fail_count++;
        give_verdict();
    end
endmodule

`default_nettype wire
